/* src/ir_timer_pkg.sv */
/*
 * Shared constants for the infrared carrier and modulation timer:
 * register word addresses, control and status field positions, and reset values.
 * Assumes a 16-bit register port with word addresses, reached from a single clock domain.
 */
package ir_timer_pkg;

  // ==========================================================================
  // register addresses (word index on the register port)
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_CARRIER  = 4'h2;
  localparam logic [3:0] ADDR_MOD_TIME = 4'h3;
  localparam logic [3:0] ADDR_VALUE    = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE  = 4'h5;
  localparam logic [3:0] ADDR_POWER    = 4'h6;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_MODE      = 1;
  localparam int CTRL_POLARITY  = 2;
  localparam int CTRL_DATA      = 3;
  localparam int CTRL_CLK_SEL   = 4;
  localparam int CTRL_BURST     = 5;
  localparam int CTRL_RELOAD    = 6;
  localparam int CTRL_EDGE_LO   = 7;
  localparam int CTRL_DIV_LO    = 9;
  localparam int CTRL_INT_EN    = 12;
  localparam int CTRL_WIDTH     = 13;

  // ==========================================================================
  // status and power control fields
  // ==========================================================================
  localparam int STAT_INT_FLAG  = 0;
  localparam int STAT_OVF_FLAG  = 1;
  localparam int PWR_LEVEL      = 0;
  localparam int PWR_OE         = 1;

  // ==========================================================================
  // reset values and counts
  // ==========================================================================
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CARRIER_RESET  = 16'h0000;
  localparam logic [15:0] MOD_TIME_RESET = 16'h0000;
  localparam logic [15:0] BURST_START    = 16'h0001;
  localparam logic [15:0] VALUE_MAX      = 16'hFFFF;
  localparam logic [1:0]  ABSENCE_CYCLES = 2'h2;

  typedef enum logic [1:0] {OP_OFF, OP_TX, OP_RX} op_mode_t;

endpackage

/* src/ir_clock_divider.sv */
/*
 * Prescaler for the infrared input clock: a one-cycle tick every 2^div system clocks.
 * Assumes div is steady for a whole tick period; a change reaches the compare mask at once, mid-period.
 */
`timescale 1ns/1ps
module ir_clock_divider
  import ir_timer_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] div,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] count;
    logic       tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [6:0] mask;

  // ==========================================================================
  // divider
  // ==========================================================================
  always_comb begin
    mask = 7'((8'h01 << div) - 8'h01);
    s_d  = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.count = 7'h00;
    end else if ((s_q.count & mask) == mask) begin
      s_d.count = 7'h00;
      s_d.tick  = 1'b1;
    end else begin
      s_d.count = s_q.count + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

/* src/ir_carrier_modulation_timer.sv */
/*
 * Infrared carrier generation and modulation timer: carrier generator, modulation
 * down counter for transmit, capture and burst counting for receive, register port.
 * Assumes the receive pin is already synchronous to clk_sys and that the emitter
 * driver follows the transmit pin and its output enable.
 */
// The plain strobed port and the placing of the registers were decided locally.
// Functional notes
// - disabled: pin follows manual level and enable
// - timer runs only while enable bit is one
// - transmit counts down from modulation time; receive up
// - receive reload on qualified edge is configurable
// - wrap from all ones sets overflow, interrupt
// - input clock is system clock over 2^div
// - high byte+1, low byte+1 input clocks
// - carrier, polarity, data latched per interval
// - down step per carrier cycle or input clock
// - enabling drives pin to polarity idle level
// - data one sends carrier, zero sends idle
// - transmit starts when enable and mode both set
// - receive lasts until transmit mode or disable
// - burst mode: no capture, modulation time counts edges
// - burst mode: two silent carrier cycles flag
// - burst mode entry sets modulation time to one
// - burst mode reload bit, edges by select field
// - normal receive: edge captures value, sets flag
`timescale 1ns/1ps
module ir_carrier_modulation_timer
  import ir_timer_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        ir_receive_pin,
  output logic             ir_transmit_pin,
  output logic             ir_transmit_oe,
  output logic             irq
);

  typedef struct packed {
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0]           carrier;
    logic [15:0]           mod_time;
    logic [15:0]           value;
    logic [15:0]           capture;
    logic                  manual_tx_level;
    logic                  manual_tx_output_enable;
    logic                  int_flag;
    logic                  ovf_flag;
    logic                  tx_active;
    logic [15:0]           car_lat;
    logic                  pol_lat;
    logic                  data_lat;
    logic                  car_high;
    logic [7:0]            phase_cnt;
    logic [1:0]            silent_cnt;
    logic                  rx_prev;
    logic                  tx_pin;
    logic                  tx_oe;
    logic                  irq;
    logic [15:0]           rdata;
  } ir_state_t;

  ir_state_t   s_q;
  ir_state_t   s_d;
  op_mode_t    op;
  logic        ir_tick;
  logic        timer_enable_bit;
  logic        direction_mode_bit;
  logic        burst_count_mode_bit;
  logic        modulation_clock_select;
  logic        receive_reload_bit;
  logic [1:0]  receive_edge_select;
  logic [2:0]  input_clock_divider;
  logic        tx_start;
  logic        carrier_end;
  logic        step;
  logic        rx_rise;
  logic        rx_fall;
  logic        qual_edge;
  logic [15:0] car_src;
  logic [15:0] rd_mux;

  assign timer_enable_bit        = s_q.ctrl[CTRL_ENABLE];
  assign direction_mode_bit      = s_q.ctrl[CTRL_MODE];
  assign burst_count_mode_bit    = s_q.ctrl[CTRL_BURST];
  assign modulation_clock_select = s_q.ctrl[CTRL_CLK_SEL];
  assign receive_reload_bit      = s_q.ctrl[CTRL_RELOAD];
  assign receive_edge_select     = s_q.ctrl[CTRL_EDGE_LO +: 2];
  assign input_clock_divider     = s_q.ctrl[CTRL_DIV_LO +: 3];

  // ==========================================================================
  // input clock prescaler
  // ==========================================================================
  ir_clock_divider u_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .run     (timer_enable_bit),
    .div     (input_clock_divider),
    .tick    (ir_tick)
  );

  // ==========================================================================
  // operating mode and edge qualification
  // ==========================================================================
  always_comb begin
    if (!timer_enable_bit) begin
      op = OP_OFF;
    end else if (direction_mode_bit) begin
      op = OP_TX;
    end else begin
      op = OP_RX;
    end
  end

  // a start is seen on entering transmit, whichever bit arrived last
  assign tx_start  = (op == OP_TX) && !s_q.tx_active;
  assign rx_rise   = ir_receive_pin && !s_q.rx_prev;
  assign rx_fall   = !ir_receive_pin && s_q.rx_prev;
  assign qual_edge = (op == OP_RX) && ((receive_edge_select[0] && rx_rise) ||
                                       (receive_edge_select[1] && rx_fall));
  // transmit works from the latched carrier, receive from the live register
  assign car_src   = (op == OP_TX) ? s_q.car_lat : s_q.carrier;

  always_comb begin
    unique case (reg_addr)
      ADDR_CTRL:     rd_mux = 16'(s_q.ctrl);
      ADDR_STATUS:   rd_mux = {14'h0000, s_q.ovf_flag, s_q.int_flag};
      ADDR_CARRIER:  rd_mux = s_q.carrier;
      ADDR_MOD_TIME: rd_mux = s_q.mod_time;
      ADDR_VALUE:    rd_mux = s_q.value;
      ADDR_CAPTURE:  rd_mux = s_q.capture;
      ADDR_POWER:    rd_mux = {14'h0000, s_q.manual_tx_output_enable, s_q.manual_tx_level};
      default:       rd_mux = 16'h0000;
    endcase
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_d         = s_q;
    carrier_end = 1'b0;
    step        = 1'b0;
    s_d.rx_prev = ir_receive_pin;
    s_d.rdata   = reg_rd ? rd_mux : 16'h0000;

    // software writes first so that hardware events below take precedence
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: begin
          s_d.ctrl = reg_wdata[CTRL_WIDTH-1:0];
          if (reg_wdata[CTRL_BURST] && !s_q.ctrl[CTRL_BURST]) begin
            s_d.mod_time = BURST_START;
          end
        end
        ADDR_STATUS: begin
          if (reg_wdata[STAT_INT_FLAG]) begin
            s_d.int_flag = 1'b0;
          end
          if (reg_wdata[STAT_OVF_FLAG]) begin
            s_d.ovf_flag = 1'b0;
          end
        end
        ADDR_CARRIER:  s_d.carrier = reg_wdata;
        ADDR_MOD_TIME: s_d.mod_time = reg_wdata;
        ADDR_VALUE:    s_d.value = reg_wdata;
        ADDR_POWER: begin
          s_d.manual_tx_level         = reg_wdata[PWR_LEVEL];
          s_d.manual_tx_output_enable = reg_wdata[PWR_OE];
        end
        default: begin
        end
      endcase
    end

    // carrier generator, stepped by the prescaled input clock
    if (op == OP_OFF || tx_start) begin
      s_d.car_high   = 1'b1;
      s_d.phase_cnt  = 8'h00;
      s_d.silent_cnt = 2'h0;
    end else if (ir_tick) begin
      if (s_q.car_high) begin
        if (s_q.phase_cnt == car_src[15:8]) begin
          s_d.car_high  = 1'b0;
          s_d.phase_cnt = 8'h00;
        end else begin
          s_d.phase_cnt = s_q.phase_cnt + 8'h01;
        end
      end else if (s_q.phase_cnt == car_src[7:0]) begin
        s_d.car_high  = 1'b1;
        s_d.phase_cnt = 8'h00;
        carrier_end   = 1'b1;
      end else begin
        s_d.phase_cnt = s_q.phase_cnt + 8'h01;
      end
    end
    step = modulation_clock_select ? ir_tick : carrier_end;

    s_d.tx_active = (op == OP_TX);
    unique case (op)
      OP_TX: begin
        if (tx_start || (step && s_q.value == 16'h0000)) begin
          s_d.value    = s_q.mod_time;
          s_d.car_lat  = s_q.carrier;
          s_d.pol_lat  = s_q.ctrl[CTRL_POLARITY];
          s_d.data_lat = s_q.ctrl[CTRL_DATA];
          if (!tx_start) begin
            s_d.int_flag = 1'b1;
          end
        end else if (step) begin
          s_d.value = s_q.value - 16'h0001;
        end
      end
      OP_RX: begin
        if (step) begin
          s_d.value = s_q.value + 16'h0001;
          if (s_q.value == VALUE_MAX) begin
            s_d.ovf_flag = 1'b1;
          end
        end
        if (qual_edge) begin
          if (receive_reload_bit) begin
            s_d.value = 16'h0000;
          end
          if (burst_count_mode_bit) begin
            s_d.mod_time   = s_q.mod_time + 16'h0001;
            s_d.silent_cnt = 2'h0;
          end else begin
            s_d.capture  = s_q.value;
            s_d.int_flag = 1'b1;
          end
        end else if (burst_count_mode_bit && carrier_end && s_q.silent_cnt != ABSENCE_CYCLES) begin
          s_d.silent_cnt = s_q.silent_cnt + 2'h1;
          if (s_q.silent_cnt + 2'h1 == ABSENCE_CYCLES) begin
            s_d.int_flag = 1'b1;
          end
        end
      end
      OP_OFF: begin
      end
    endcase

    // pin driver
    if (op == OP_OFF) begin
      s_d.tx_pin = s_q.manual_tx_level;
      s_d.tx_oe  = s_q.manual_tx_output_enable;
    end else if (op == OP_RX || tx_start) begin
      s_d.tx_pin = s_q.ctrl[CTRL_POLARITY];
      s_d.tx_oe  = 1'b1;
    end else begin
      s_d.tx_pin = s_q.data_lat ? (s_q.car_high ^ s_q.pol_lat) : s_q.pol_lat;
      s_d.tx_oe  = 1'b1;
    end
    s_d.irq = s_q.ctrl[CTRL_INT_EN] && (s_q.int_flag || s_q.ovf_flag);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.ctrl     <= CTRL_RESET[CTRL_WIDTH-1:0];
      s_q.carrier  <= CARRIER_RESET;
      s_q.mod_time <= MOD_TIME_RESET;
      s_q.car_high <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata       = s_q.rdata;
  assign ir_transmit_pin = s_q.tx_pin;
  assign ir_transmit_oe  = s_q.tx_oe;
  assign irq             = s_q.irq;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence tx_interval_end_s;
    (op == OP_TX) && !tx_start && step && s_q.value == 16'h0000;
  endsequence

  sequence tx_reloaded_s;
    s_q.int_flag && s_q.value == $past(s_q.mod_time) && s_q.car_lat == $past(s_q.carrier);
  endsequence

  disabled_pin_a: assert property ((op == OP_OFF) |=>
      s_q.tx_pin == $past(s_q.manual_tx_level) && s_q.tx_oe == $past(s_q.manual_tx_output_enable))
    else $error("pin not under manual control while disabled");

  off_frozen_a: assert property ((op == OP_OFF) && !reg_wr |=> $stable(s_q.value))
    else $error("value counter moved while disabled");

  tx_start_a: assert property (tx_start |=>
      s_q.value == $past(s_q.mod_time) && s_q.tx_pin == $past(s_q.ctrl[CTRL_POLARITY]) && s_q.tx_oe)
    else $error("transmit start did not load and idle the pin");

  tx_reload_a: assert property (tx_interval_end_s |=> tx_reloaded_s)
    else $error("interval end did not reload and flag");

  tx_count_a: assert property ((op == OP_TX) && !tx_start && step && s_q.value != 16'h0000 && !reg_wr
      |=> s_q.value == $past(s_q.value) - 16'h0001)
    else $error("transmit down count wrong");

  rx_overflow_a: assert property ((op == OP_RX) && step && !qual_edge && s_q.value == VALUE_MAX && !reg_wr
      |=> s_q.ovf_flag && s_q.value == 16'h0000)
    else $error("overflow not flagged on wrap");

  rx_capture_a: assert property ((op == OP_RX) && qual_edge && !burst_count_mode_bit && !reg_wr
      |=> s_q.int_flag && s_q.capture == $past(s_q.value))
    else $error("capture missing on qualified edge");

  burst_entry_a: assert property (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_BURST]
      && !burst_count_mode_bit |=> s_q.mod_time == BURST_START)
    else $error("burst entry did not preset modulation time");

  burst_edge_a: assert property ((op == OP_RX) && qual_edge && burst_count_mode_bit && !reg_wr
      |=> s_q.mod_time == $past(s_q.mod_time) + 16'h0001 && $stable(s_q.capture))
    else $error("burst edge not counted");

  // receive keeps the emitter parked at the idle level
  rx_pin_idle_a: assert property ((op == OP_RX) |=>
      s_q.tx_pin == $past(s_q.ctrl[CTRL_POLARITY]) && s_q.tx_oe)
    else $error("receive mode pin not at idle level");

  tx_idle_data_a: assert property ((op == OP_TX) && !tx_start && !s_q.data_lat
      |=> s_q.tx_pin == $past(s_q.pol_lat) && s_q.tx_oe)
    else $error("data zero interval not idle");

  // second silent carrier end is the one that flags the space
  absence_flag_a: assert property ((op == OP_RX) && burst_count_mode_bit && !qual_edge && carrier_end
      && s_q.silent_cnt + 2'h1 == ABSENCE_CYCLES |=> s_q.int_flag)
    else $error("carrier absence not flagged");

  irq_overflow_a: assert property (s_q.ctrl[CTRL_INT_EN] && s_q.ovf_flag |=> irq)
    else $error("overflow interrupt not raised");

  step_per_carrier_a: assert property ((op == OP_TX) && !tx_start && !modulation_clock_select
      && !carrier_end && !reg_wr |=> $stable(s_q.value))
    else $error("down count stepped between carrier cycles");

endmodule

/* verification/ir_link_model.sv */
/*
 * Far-side model: infrared detector feeding the receive pin.
 * Assumes go is a one-cycle request from the bench; the detector output rests low.
 */
`timescale 1ns/1ps
module ir_link_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic [3:0] n,
  output logic            ir_receive_pin
);
  // ==========================================================================
  // pulse train: n pulses, two cycles high, two cycles low
  // ==========================================================================
  logic [1:0] ph_q;
  logic [3:0] left_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ph_q   <= 2'h0;
      left_q <= 4'h0;
    end else if (go) begin
      ph_q   <= 2'h0;
      left_q <= n;
    end else if (left_q != 4'h0) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        left_q <= left_q - 4'h1;
      end
    end
  end

  assign ir_receive_pin = (left_q != 4'h0) && !ph_q[1];
endmodule

/* verification/test_ir_carrier_modulation_timer.sv */
/*
 * Self-checking bench for the infrared carrier and modulation timer.
 * Assumes the register map of ir_timer_pkg and a divider tick every 2^div clocks.
 */
`timescale 1ns/1ps
module test_ir_carrier_modulation_timer
  import ir_timer_pkg::*;
;
  logic        clk_sys, nrst, reg_wr, reg_rd, go, ir_receive_pin, ir_transmit_pin, ir_transmit_oe, irq;
  logic [3:0]  reg_addr, n;
  logic [15:0] reg_wdata, reg_rdata, rv;
  int          mismatches, cmp_count, cyc;

  localparam logic [15:0] EN  = 16'h0001 << CTRL_ENABLE;
  localparam logic [15:0] TX  = 16'h0001 << CTRL_MODE;
  localparam logic [15:0] POL = 16'h0001 << CTRL_POLARITY;
  localparam logic [15:0] DAT = 16'h0001 << CTRL_DATA;
  localparam logic [15:0] SEL = 16'h0001 << CTRL_CLK_SEL;
  localparam logic [15:0] BRS = 16'h0001 << CTRL_BURST;
  localparam logic [15:0] RLD = 16'h0001 << CTRL_RELOAD;
  localparam logic [15:0] RIS = 16'h0001 << CTRL_EDGE_LO;
  localparam logic [15:0] FAL = 16'h0001 << (CTRL_EDGE_LO + 1);
  localparam logic [15:0] IEN = 16'h0001 << CTRL_INT_EN;

  ir_carrier_modulation_timer i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ir_receive_pin(ir_receive_pin),
    .ir_transmit_pin(ir_transmit_pin), .ir_transmit_oe(ir_transmit_oe), .irq(irq));
  ir_link_model i_link (.clk_sys(clk_sys), .nrst(nrst), .go(go), .n(n), .ir_receive_pin(ir_receive_pin));

  // ==========================================================================
  // clock, timeout, shared tasks
  // ==========================================================================
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic stop();
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_STATUS, 16'h0003);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset_manual();
    #1 chk("pin at reset", {15'h0, ir_transmit_pin}, 16'h0000);
    chk("oe at reset", {15'h0, ir_transmit_oe}, 16'h0000);
    rd(ADDR_CTRL);
    chk("ctrl reset", rv, CTRL_RESET);
    wr(4'h7, 16'hFFFF);
    rd(4'h7);
    chk("unmapped", rv, 16'h0000);
    wr(ADDR_POWER, 16'h0003);
    idle(2);
    chk("manual high", {14'h0, ir_transmit_oe, ir_transmit_pin}, 16'h0003);
    wr(ADDR_POWER, 16'h0002);
    idle(2);
    chk("manual low", {14'h0, ir_transmit_oe, ir_transmit_pin}, 16'h0002);
  endtask

  // high and low runs of the carrier on the pin at a given divider
  task automatic t_carrier(input int dv, input logic [15:0] pl);
    int h;
    int l;
    int w;
    h = 0;
    l = 0;
    w = 0;
    wr(ADDR_CARRIER, 16'h0201);
    wr(ADDR_MOD_TIME, 16'h0040);
    wr(ADDR_CTRL, EN | TX | DAT | pl | 16'(dv << CTRL_DIV_LO));
    idle(2);
    chk("oe on enable", {15'h0, ir_transmit_oe}, 16'h0001);
    while (ir_transmit_pin !== 1'b0 && w < 100) begin idle(1); w++; end
    while (ir_transmit_pin !== 1'b1 && w < 100) begin idle(1); w++; end
    while (ir_transmit_pin === 1'b1 && w < 100) begin idle(1); h++; w++; end
    while (ir_transmit_pin === 1'b0 && w < 100) begin idle(1); l++; w++; end
    chk("carrier high run", 16'(h), 16'(((pl != 16'h0000) ? 2 : 3) << dv));
    chk("carrier low run", 16'(l), 16'(((pl != 16'h0000) ? 3 : 2) << dv));
    stop();
  endtask

  // data zero with polarity one: pin rests high for 30 sampled cycles of the interval
  task automatic t_idle_level();
    int hi;
    hi = 0;
    wr(ADDR_CARRIER, 16'h0000);
    wr(ADDR_MOD_TIME, 16'h0040);
    wr(ADDR_CTRL, EN | TX | POL);
    idle(2);
    repeat (30) begin idle(1); hi += int'(ir_transmit_pin === 1'b1); end
    chk("idle level cycles", 16'(hi), 16'd30);
    stop();
  endtask

  // interval end timing: per input clock is far quicker than per carrier cycle
  task automatic t_interval(input logic [15:0] sel);
    int c;
    c = 0;
    wr(ADDR_CARRIER, 16'h0201);
    wr(ADDR_MOD_TIME, 16'h0005);
    wr(ADDR_CTRL, EN | TX | IEN | sel);
    while (irq !== 1'b1 && c < 80) begin idle(1); c++; end
    chk("interval end in window", 16'((sel != 0) ? (c <= 12) : (c >= 20 && c < 80)), 16'h0001);
    stop();
    rd(ADDR_STATUS);
    chk("flag cleared", rv, 16'h0000);
  endtask

  task automatic t_capture(input logic [15:0] es, input logic [15:0] base);
    logic [15:0] cap;
    wr(ADDR_VALUE, base);
    wr(ADDR_CTRL, EN | SEL | RLD | es);
    @(posedge clk_sys);
    go <= 1'b1;
    n  <= 4'h1;
    @(posedge clk_sys);
    go <= 1'b0;
    idle(20);
    rd(ADDR_STATUS);
    chk("capture flag", rv & 16'h0001, 16'h0001);
    rd(ADDR_CAPTURE);
    cap = rv;
    chk("capture counted up", 16'(cap > base && cap < base + 16'h0020), 16'h0001);
    rd(ADDR_VALUE);
    chk("value reloaded", 16'(rv < 16'h0020), 16'h0001);
    stop();
  endtask

  task automatic t_overflow();
    wr(ADDR_VALUE, 16'hFFF8);
    wr(ADDR_CTRL, EN | SEL);
    idle(30);
    rd(ADDR_STATUS);
    chk("overflow flag", rv, 16'h0002);
    wr(ADDR_CTRL, EN | SEL | IEN);
    idle(2);
    chk("overflow irq", {15'h0, irq}, 16'h0001);
    stop();
  endtask

  task automatic t_burst();
    logic [15:0] cap;
    // capture keeps its value from earlier receive runs
    rd(ADDR_CAPTURE);
    cap = rv;
    wr(ADDR_CARRIER, 16'h0707);
    wr(ADDR_CTRL, EN | SEL | BRS | RIS);
    rd(ADDR_MOD_TIME);
    chk("burst entry count", rv, BURST_START);
    @(posedge clk_sys);
    go <= 1'b1;
    n  <= 4'h3;
    @(posedge clk_sys);
    go <= 1'b0;
    idle(14);
    wr(ADDR_STATUS, 16'h0003);
    rd(ADDR_MOD_TIME);
    chk("burst edge count", rv, 16'h0004);
    rd(ADDR_CAPTURE);
    chk("no capture in burst", rv, cap);
    idle(80);
    rd(ADDR_STATUS);
    chk("absence flag", rv & 16'h0001, 16'h0001);
    stop();
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    go = 1'b0;
    n = 4'h0;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset_manual();
    t_carrier(0, 16'h0000);
    t_carrier(1, 16'h0000);
    t_carrier(0, POL);
    t_idle_level();
    t_interval(SEL);
    t_interval(16'h0000);
    t_capture(RIS, 16'h0100);
    t_capture(FAL, 16'h0200);
    t_overflow();
    t_burst();
    end_sim();
  end
endmodule
